/* rtl/eapl_defines.vh */
// Purpose: Constants for the alert pulse block
// Assumes: 200 MHz reference clock, 5 ns period
// Notes on behaviour
// - An alert-worthy event in Normal or Stop mode drives the pin low for the pulse width, then drives it high again.
// - The pin stays high for at least the minimum gap between two pulses.
// - Emitting a pulse never changes the operating mode.
// - Class select 0 means wake-only alerts (default), 1 means wake plus failure alerts.
// - In wake class a wake event alerts only when its source is enabled for wake-up.
// - In global class failures also alert, and the wake pin level register never does.
// - Core undervoltage, watchdog fail, core short, thermal level two, fail output, power-on and device state never alert.
// - A Stop command with any wake status bit still set raises a pulse.
// - Readable event status registers update at each falling edge of the pulse; the wake level register updates every cycle.
// - Captured events stay latched until cleared by host command; the wake level register is not latched.
// - In Init mode the pin acts as a configuration selector sensed by level.
// - The configuration level is filtered for about 7 us before it is accepted.
`ifndef EAPL_DEFINES_VH
`define EAPL_DEFINES_VH
`define EAPL_CLK_MHZ 200
`define EAPL_PULSE_US 100
`define EAPL_GAP_US 100
`define EAPL_CFG_FLT_US 7
`define EAPL_PULSE_CYC (`EAPL_PULSE_US * `EAPL_CLK_MHZ)
`define EAPL_GAP_CYC (`EAPL_GAP_US * `EAPL_CLK_MHZ)
`define EAPL_CFG_FLT_CYC (`EAPL_CFG_FLT_US * `EAPL_CLK_MHZ)
`define EAPL_MODE_INIT 2'h0
`define EAPL_MODE_NORMAL 2'h1
`define EAPL_MODE_STOP 2'h2
`define EAPL_MODE_OTHER 2'h3
`endif

/* rtl/eapl_alert.v */
// Purpose: Active-low alert pulse and Init-mode configuration sensing
// Assumes: Status event inputs are same-clock pulses; pin input is async
// Notes: Pulse and gap counts exceed 4096 cycles, so they are parameters
`timescale 1ns/1ps
`include "eapl_defines.vh"
module eapl_alert #(
  parameter W = 8,
  parameter F = 8,
  parameter PULSE_CYC = `EAPL_PULSE_CYC,
  parameter GAP_CYC = `EAPL_GAP_CYC,
  parameter CFG_FLT_CYC = `EAPL_CFG_FLT_CYC
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [1:0] mode_i,
  input wire class_global_i,
  input wire [W-1:0] wake_one_event_i,
  input wire [W-1:0] wake_one_enable_i,
  input wire [W-1:0] wake_two_event_i,
  input wire [W-1:0] wake_two_enable_i,
  input wire [W-1:0] wake_one_clear_i,
  input wire [W-1:0] wake_two_clear_i,
  input wire [F-1:0] fail_event_i,
  input wire [F-1:0] fail_clear_i,
  input wire [W-1:0] wake_level_i,
  input wire stop_cmd_i,
  input wire alert_pin_i,
  output reg alert_n_o,
  output reg alert_oe_o,
  output reg [W-1:0] wake_event_status_one_o,
  output reg [W-1:0] wake_event_status_two_o,
  output reg [F-1:0] fail_status_o,
  output reg [W-1:0] wake_pin_level_status_o,
  output reg cfg_sel_o,
  output reg cfg_valid_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PULSE = 2'h1;
  localparam ST_GAP = 2'h2;
  localparam ST_SPARE = 2'h3;
  localparam CW = 16;
  localparam [CW-1:0] CNT_ZERO = 16'h0000;
  localparam [CW-1:0] CNT_ONE = 16'h0001;
  // Counts run down to zero, so each load is one short
  localparam [CW-1:0] PULSE_LOAD = PULSE_CYC[CW-1:0] - CNT_ONE;
  localparam [CW-1:0] GAP_LOAD = GAP_CYC[CW-1:0] - CNT_ONE;
  localparam [CW-1:0] FLT_LAST = CFG_FLT_CYC[CW-1:0] - CNT_ONE;

  // Pulse sequencer
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;
  reg pend_q;
  reg pend_d;
  reg alert_n_d;
  reg alert_oe_d;

  // Event latches and visible status copies
  reg [W-1:0] lat_one_q;
  reg [W-1:0] lat_one_d;
  reg [W-1:0] lat_two_q;
  reg [W-1:0] lat_two_d;
  reg [F-1:0] lat_fail_q;
  reg [F-1:0] lat_fail_d;
  reg [W-1:0] vis_one_d;
  reg [W-1:0] vis_two_d;
  reg [F-1:0] vis_fail_d;
  reg [W-1:0] lvl_d;

  // Configuration pin sensing
  reg pin_s1_q;
  reg pin_s2_q;
  reg flt_lvl_q;
  reg [CW-1:0] flt_q;
  reg [CW-1:0] flt_d;
  reg cfg_sel_d;
  reg cfg_valid_d;

  wire new_one;
  wire new_two;
  wire new_fail;
  wire any_wake;
  wire stop_trig;
  wire trig;
  wire run;
  wire in_init;

  // Set beats clear so an event in the clear cycle survives
  function [W-1:0] wake_lat_nx;
    input [W-1:0] cur;
    input [W-1:0] clr;
    input [W-1:0] set;
    begin
      wake_lat_nx = (cur & ~clr) | set;
    end
  endfunction

  // Same rule for the failure latches
  function [F-1:0] fail_lat_nx;
    input [F-1:0] cur;
    input [F-1:0] clr;
    input [F-1:0] set;
    begin
      fail_lat_nx = (cur & ~clr) | set;
    end
  endfunction

  // Zero marks the last cycle of a phase
  function cnt_done;
    input [CW-1:0] cnt;
    begin
      cnt_done = (cnt == CNT_ZERO);
    end
  endfunction

  function [CW-1:0] cnt_dec;
    input [CW-1:0] cnt;
    begin
      cnt_dec = cnt - CNT_ONE;
    end
  endfunction

  function mode_is_init;
    input [1:0] md;
    begin
      mode_is_init = (md == `EAPL_MODE_INIT);
    end
  endfunction

  // Alerts only in Normal and Stop mode
  function mode_is_run;
    input [1:0] md;
    begin
      mode_is_run = (md == `EAPL_MODE_NORMAL) | (md == `EAPL_MODE_STOP);
    end
  endfunction

  // Failures that force reset or fail-safe stay off fail_event_i
  assign new_one = |(wake_one_event_i & wake_one_enable_i);
  assign new_two = |(wake_two_event_i & wake_two_enable_i);
  assign new_fail = class_global_i & (|fail_event_i);
  assign any_wake = (|lat_one_q) | (|lat_two_q);
  assign stop_trig = stop_cmd_i & any_wake;
  assign run = mode_is_run(mode_i);
  assign in_init = mode_is_init(mode_i);
  assign trig = new_one | new_two | new_fail | stop_trig;

  always @* begin
    lat_one_d = wake_lat_nx(lat_one_q, wake_one_clear_i,
      wake_one_event_i);
    lat_two_d = wake_lat_nx(lat_two_q, wake_two_clear_i,
      wake_two_event_i);
    lat_fail_d = fail_lat_nx(lat_fail_q, fail_clear_i,
      fail_event_i);
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      lat_one_q <= {W{1'b0}};
      lat_two_q <= {W{1'b0}};
      lat_fail_q <= {F{1'b0}};
    end else begin
      lat_one_q <= lat_one_d;
      lat_two_q <= lat_two_d;
      lat_fail_q <= lat_fail_d;
    end
  end

  // No mode output exists, so a pulse cannot change the mode
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    alert_n_d = alert_n_o;
    // Pin driven outside Init, released there for config sensing
    alert_oe_d = ~in_init;
    // Level register is live, never latched
    lvl_d = wake_level_i;
    // Clears reach the visible copy at once
    vis_one_d = wake_event_status_one_o & ~wake_one_clear_i;
    vis_two_d = wake_event_status_two_o & ~wake_two_clear_i;
    vis_fail_d = fail_status_o & ~fail_clear_i;
    case (st_q)
      ST_IDLE: begin
        if (run & (trig | pend_q)) begin
          st_d = ST_PULSE;
          cnt_d = PULSE_LOAD;
          pend_d = 1'b0;
          alert_n_d = 1'b0;
          // Next latch value, so the triggering event shows as well
          vis_one_d = lat_one_d;
          vis_two_d = lat_two_d;
          vis_fail_d = lat_fail_d;
        end else if (!run) begin
          // Held events are dropped outside Normal and Stop
          pend_d = 1'b0;
        end
      end
      ST_PULSE: begin
        if (trig) begin
          pend_d = 1'b1;
        end
        if (cnt_done(cnt_q)) begin
          st_d = ST_GAP;
          cnt_d = GAP_LOAD;
          alert_n_d = 1'b1;
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      ST_GAP: begin
        if (trig) begin
          pend_d = 1'b1;
        end
        if (cnt_done(cnt_q)) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      default: begin
        st_d = ST_IDLE;
        cnt_d = CNT_ZERO;
        alert_n_d = 1'b1;
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
    end
  end

  // Outputs straight from flops
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      alert_n_o <= 1'b1;
      alert_oe_o <= 1'b0;
      wake_event_status_one_o <= {W{1'b0}};
      wake_event_status_two_o <= {W{1'b0}};
      fail_status_o <= {F{1'b0}};
      wake_pin_level_status_o <= {W{1'b0}};
    end else begin
      alert_n_o <= alert_n_d;
      alert_oe_o <= alert_oe_d;
      wake_event_status_one_o <= vis_one_d;
      wake_event_status_two_o <= vis_two_d;
      fail_status_o <= vis_fail_d;
      wake_pin_level_status_o <= lvl_d;
    end
  end

  // Two flops before any logic reads the pin
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      flt_lvl_q <= 1'b0;
    end else begin
      pin_s1_q <= alert_pin_i;
      pin_s2_q <= pin_s1_q;
      flt_lvl_q <= pin_s2_q;
    end
  end

  // Filter restarts on any change, so a short glitch never selects
  always @* begin
    flt_d = flt_q;
    cfg_sel_d = cfg_sel_o;
    cfg_valid_d = cfg_valid_o;
    if (!in_init) begin
      flt_d = CNT_ZERO;
    end else if (pin_s2_q != flt_lvl_q) begin
      flt_d = CNT_ZERO;
    end else if (flt_q < FLT_LAST) begin
      flt_d = flt_q + CNT_ONE;
    end else begin
      cfg_sel_d = flt_lvl_q;
      cfg_valid_d = 1'b1;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flt_q <= CNT_ZERO;
      cfg_sel_o <= 1'b0;
      cfg_valid_o <= 1'b0;
    end else begin
      flt_q <= flt_d;
      cfg_sel_o <= cfg_sel_d;
      cfg_valid_o <= cfg_valid_d;
    end
  end
endmodule

/* verif/eapl_alert_monitor.sv */
// Purpose: Alert pulse checker
// Assumes: 8 wake sources
// Notes: Gap count saturates
`timescale 1ns/1ps
module eapl_alert_monitor #(
  parameter PULSE_CYC = 20,
  parameter GAP_CYC = 20
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [1:0] mode_i,
  input wire [7:0] wake_one_event_i,
  input wire [7:0] wake_one_enable_i,
  input wire [7:0] wake_one_clear_i,
  input wire [7:0] wake_level_i,
  input wire alert_n_o,
  input wire alert_oe_o,
  input wire [7:0] wake_event_status_one_o,
  input wire [7:0] wake_pin_level_status_o
);
  reg [15:0] lo_q;
  reg [15:0] hi_q;
  wire clr = |wake_one_clear_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Seeded so a first pulse after reset passes
  always @(posedge ref_clk_i) begin
    lo_q <= (!rst_n_i || alert_n_o) ? 16'h0000 : lo_q + 16'h0001;
    hi_q <= !rst_n_i ? 16'(GAP_CYC) : !alert_n_o ? 16'h0000 :
      hi_q + {15'h0000, ~&hi_q};
  end
  a_pulse_width: assert property ($rose(alert_n_o) |-> lo_q == PULSE_CYC)
    else $error("width");
  a_min_gap: assert property ($fell(alert_n_o) |-> hi_q >= GAP_CYC)
    else $error("gap");
  a_wake_alert: assert property (alert_n_o && hi_q > GAP_CYC + 2 &&
    mode_i == 2'h1 && |(wake_one_event_i & wake_one_enable_i) |=> !alert_n_o)
    else $error("missed");
  a_mode_gate: assert property ($fell(alert_n_o) |->
    $past(mode_i) inside {2'h1, 2'h2}) else $error("mode");
  a_oe_init: assert property ($past(rst_n_i) |->
    alert_oe_o == ($past(mode_i) != 2'h0)) else $error("oe");
  a_level_copy: assert property ($past(rst_n_i) |->
    wake_pin_level_status_o == $past(wake_level_i)) else $error("level");
  a_status_update: assert property ($changed(wake_event_status_one_o) |->
    $fell(alert_n_o) || $past(clr) || $past(clr, 2)) else $error("update");
  a_status_hold: assert property (|($past(wake_event_status_one_o) &
    ~wake_event_status_one_o) |-> $past(clr) || $past(clr, 2))
    else $error("lost");
endmodule
bind eapl_alert eapl_alert_monitor #(.PULSE_CYC(PULSE_CYC),
  .GAP_CYC(GAP_CYC)) u_eapl_alert_monitor (.*);

/* verif/eapl_mcu.sv */
// Purpose: Host model
// Assumes: Clears all at pulse end
// Notes: svc_i low leaves events set
`timescale 1ns/1ps
module eapl_mcu (
  input wire ref_clk_i,
  input wire alert_n_i,
  input wire svc_i,
  input wire [23:0] st_i,
  output reg [23:0] clr_o
);
  reg a_q = 1'b1;
  initial clr_o = 24'h00_0000;
  always @(posedge ref_clk_i) begin
    a_q <= alert_n_i;
    clr_o <= (svc_i && alert_n_i && !a_q) ? st_i : 24'h00_0000;
  end
endmodule

/* verif/eapl_alert_tb.sv */
// Purpose: Alert bench
// Assumes: Short counts
// Notes: Pin is driver or bench
`timescale 1ns/1ps
module eapl_alert_tb;
  localparam P = 20;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] md = 2'h1;
  reg cls = 1'b0, stp = 1'b0, cfg = 1'b0, svc = 1'b1;
  reg [7:0] e1 = 8'h00, n1 = 8'h00, e2 = 8'h00, fe = 8'h00, lv = 8'h00;
  reg [7:0] n2 = 8'h80;
  wire an, oe, cs, cv;
  wire [7:0] s1, s2, sf, ls;
  wire [23:0] clr;
  wire pin = oe ? an : cfg;
  wire [7:0] a8 = {7'h00, an};
  integer fail_count = 0, total_checks = 0, cy = 0, i;
  eapl_alert #(.PULSE_CYC(P), .GAP_CYC(P), .CFG_FLT_CYC(5)) u_eapl_alert (
    .ref_clk_i(clk), .rst_n_i(rst_n), .mode_i(md), .class_global_i(cls),
    .wake_one_event_i(e1), .wake_one_enable_i(n1), .wake_two_event_i(e2),
    .wake_two_enable_i(n2), .wake_one_clear_i(clr[7:0]),
    .wake_two_clear_i(clr[15:8]), .fail_event_i(fe),
    .fail_clear_i(clr[23:16]), .wake_level_i(lv), .stop_cmd_i(stp),
    .alert_pin_i(pin), .alert_n_o(an), .alert_oe_o(oe),
    .wake_event_status_one_o(s1), .wake_event_status_two_o(s2),
    .fail_status_o(sf), .wake_pin_level_status_o(ls), .cfg_sel_o(cs),
    .cfg_valid_o(cv));
  eapl_mcu u_eapl_mcu (.ref_clk_i(clk), .alert_n_i(an), .svc_i(svc),
    .st_i({sf, s2, s1}), .clr_o(clr));
  initial forever #2.5 clk = ~clk;
  task chk(input [7:0] g, input [7:0] x);
    begin
      total_checks = total_checks + 1;
      if (g !== x) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task wf(input integer n);
    begin
      @(negedge clk);
      for (i = 0; i < n && an !== 1'b0; i = i + 1) @(negedge clk);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Waits out any pulse and its gap, ends on a rising edge
  task quiet;
    begin
      @(negedge clk);
      while (an !== 1'b1) @(negedge clk);
      cyc(P + 2);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d fails %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Wake pulse, status load, held event
  task t_wake;
    begin
      cyc(4);
      n1 <= 8'h01;
      e1 <= 8'h01;
      cyc(1);
      e1 <= 8'h00;
      wf(3);
      chk(a8, 8'h00);
      chk(s1, 8'h01);
      cyc(1);
      e2 <= 8'h80;
      cyc(1);
      e2 <= 8'h00;
      cyc(P + 4);
      wf(P + P);
      chk(a8, 8'h00);
      chk(s2, 8'h80);
      $display("wake end");
    end
  endtask
  // Class select, then Stop with pending bits
  task t_stop;
    begin
      quiet;
      e1 <= 8'h02;
      e2 <= 8'h40;
      fe <= 8'h10;
      cyc(1);
      e1 <= 8'h00;
      e2 <= 8'h00;
      fe <= 8'h00;
      wf(P);
      chk(a8, 8'h01);
      cyc(1);
      cls <= 1'b1;
      svc <= 1'b0;
      fe <= 8'h08;
      cyc(1);
      fe <= 8'h00;
      wf(3);
      chk(a8, 8'h00);
      chk(sf, 8'h18);
      cyc(1);
      cls <= 1'b0;
      quiet;
      md <= 2'h2;
      stp <= 1'b1;
      cyc(1);
      stp <= 1'b0;
      wf(3);
      chk(a8, 8'h00);
      chk(s1, 8'h02);
      cyc(1);
      svc <= 1'b1;
      quiet;
      wf(0);
      chk(s1, 8'h00);
      chk(s2, 8'h00);
      cyc(1);
      stp <= 1'b1;
      cyc(1);
      stp <= 1'b0;
      wf(P);
      chk(a8, 8'h01);
      $display("stop end");
    end
  endtask
  // Init mode pin sensing with a short glitch
  task t_init;
    begin
      cyc(1);
      md <= 2'h0;
      cfg <= 1'b1;
      lv <= 8'h5a;
      e1 <= 8'h01;
      cyc(1);
      e1 <= 8'h00;
      cyc(12);
      wf(0);
      chk({6'h00, oe, an}, 8'h01);
      chk(ls, 8'h5a);
      cyc(1);
      cfg <= 1'b0;
      cyc(2);
      cfg <= 1'b1;
      cyc(2);
      wf(0);
      chk({6'h00, cv, cs}, 8'h03);
      cyc(1);
      cfg <= 1'b0;
      cyc(12);
      wf(0);
      chk({6'h00, cv, cs}, 8'h02);
      $display("init end");
    end
  endtask
  always @(posedge clk) begin
    cy <= cy + 1;
    if (cy == 5000) begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    t_wake;
    t_stop;
    t_init;
    summarize;
  end
endmodule
